/* hdl/mcms_pkg.sv */
// shared constants and carrier types for the collision and management status block
`default_nettype none
package mcms_pkg;
    localparam int          CW_W          = 6;
    localparam int          RETRY_W       = 4;
    localparam int          IND_W         = 4;
    localparam logic [5:0]  CWIN_RST      = 6'h37;
    localparam logic [3:0]  RETRY_ATTEMPT_LIMIT_RST      = 4'hf;
    localparam logic [3:0]  MIND_RST      = 4'h0;
    localparam int          CWIN_LSB      = 8;
    localparam int          RETRY_ATTEMPT_LIMIT_LSB      = 0;
    localparam int          IND_LINK      = 3;
    localparam int          IND_PEND      = 2;
    localparam int          IND_SCAN      = 1;
    localparam int          IND_BUSY      = 0;
    localparam logic [31:0] CLRT_IMPL     = 32'h0000_3f0f;
    localparam logic [31:0] MIND_IMPL     = 32'h0000_000f;
    localparam logic [31:0] OFF_CLRT      = 32'h0000_0000;
    localparam logic [31:0] OFF_MIND      = 32'h0000_0010;
    localparam int          REG_SEL_BIT   = 4;
    localparam int          MAP_TOP_LSB   = 5;
    localparam logic [1:0]  OP_BASE       = 2'h0;
    localparam logic [1:0]  OP_CLR        = 2'h1;
    localparam logic [1:0]  OP_SET        = 2'h2;
    localparam logic [1:0]  OP_INV        = 2'h3;
    localparam logic [2:0]  HSIZE_HALF    = 3'h1;
    localparam logic [2:0]  HSIZE_WORD    = 3'h2;
    localparam logic [31:0] LANE_LO       = 32'h0000_ffff;
    localparam logic [31:0] LANE_HI       = 32'hffff_0000;
    localparam logic [31:0] LANE_ALL      = 32'hffff_ffff;

    typedef struct packed {
        logic start;
        logic is_read;
        logic done;
        logic rdata_captured;
        logic scan_active;
        logic status_valid;
        logic link_fail;
    } mcms_mgmt_evt_t;

    typedef struct packed {
        logic start;
        logic byte_tick;
        logic collision;
        logic done;
    } mcms_tx_evt_t;

    typedef struct packed {
        logic retry;
        logic abort;
        logic late;
    } mcms_coll_res_t;
endpackage
`default_nettype wire

/* hdl/mcms_coll_win.sv */
// collision window byte counter and retransmission limit tracker
`timescale 1ns/100ps
`default_nettype none
module mcms_coll_win #(
    parameter int CW_W    = 6,
    parameter int RETRY_W = 4
) (
    input  wire logic                   hclk,
    input  wire logic                   hresetn,
    input  wire mcms_pkg::mcms_tx_evt_t tx_evt,
    input  wire logic [CW_W-1:0]        window_bytes,
    input  wire logic [RETRY_W-1:0]     retry_limit,
    output var  mcms_pkg::mcms_coll_res_t coll_res
);
    import mcms_pkg::*;

    logic [CW_W-1:0]    bytes_q;
    logic [RETRY_W-1:0] attempts_q;
    logic               in_window;

    // saturating: once past the window the exact count no longer matters
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            bytes_q <= '0;
        end else if (tx_evt.start) begin
            bytes_q <= '0;
        end else if (tx_evt.byte_tick && bytes_q != {CW_W{1'b1}}) begin
            bytes_q <= bytes_q + 1'b1;
        end
    end

    assign in_window = bytes_q < window_bytes;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            attempts_q <= '0;
        end else if (tx_evt.start && attempts_q == '0) begin
            attempts_q <= '0;
        end else if (tx_evt.done) begin
            attempts_q <= '0;
        end else if (tx_evt.collision && in_window) begin
            if (attempts_q == retry_limit) begin
                attempts_q <= '0;
            end else begin
                attempts_q <= attempts_q + 1'b1;
            end
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            coll_res <= '0;
        end else begin
            coll_res.retry <= tx_evt.collision && in_window && attempts_q != retry_limit;
            coll_res.abort <= tx_evt.collision && in_window && attempts_q == retry_limit;
            coll_res.late  <= tx_evt.collision && !in_window;
        end
    end

    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);

    sequence s_start_then_tick;
        tx_evt.start ##1 (tx_evt.byte_tick && !tx_evt.start);
    endsequence

    window_restart_a: assert property (s_start_then_tick |=> bytes_q == 1)
        else $error("byte count not restarted at transmission start");
    limit_abort_a: assert property (tx_evt.collision && in_window && attempts_q == retry_limit
        |=> coll_res.abort && !coll_res.retry)
        else $error("no abort when retry limit reached");
    late_coll_a: assert property (tx_evt.collision && bytes_q >= window_bytes
        |=> coll_res.late && !coll_res.abort)
        else $error("collision outside window not flagged late");
endmodule
`default_nettype wire

/* hdl/mcms_top.sv */
// mac collision window/retry limit and management indicator registers on ahb-lite
// Functional notes
// - six-bit collision window field, bits 13:8
// - window count starts at transmission, includes preamble
// - window field resets to 0x37
// - four-bit retry limit; abort when exhausted
// - retry limit resets to 0xF
// - halfword and word access; byte access ignored
// - link failure bit mirrors last PHY status; here a write to the indicator register also changes it
// - read pending while management read incomplete; here indicator register writes can also set or clear it
// - scan bit set while scanning active
// - busy while management read or write runs; here indicator register writes can also set or clear it
// - unimplemented bits read as zero
//
// Chosen here: the AHB-Lite slave port and the placing of the registers.
`timescale 1ns/100ps
`default_nettype none
module mcms_top #(
    parameter int CW_W    = 6,
    parameter int RETRY_W = 4
) (
    input  wire logic                     hclk,
    input  wire logic                     hresetn,
    input  wire logic                     hsel,
    input  wire logic [31:0]              haddr,
    input  wire logic [1:0]               htrans,
    input  wire logic                     hwrite,
    input  wire logic [2:0]               hsize,
    input  wire logic [31:0]              hwdata,
    input  wire logic                     hready,
    output var  logic [31:0]              hrdata,
    output var  logic                     hreadyout,
    output var  logic                     hresp,
    input  wire mcms_pkg::mcms_mgmt_evt_t mgmt_evt,
    input  wire mcms_pkg::mcms_tx_evt_t   tx_evt,
    output var  logic [CW_W-1:0]          collision_window_bytes,
    output var  logic [RETRY_W-1:0]       retry_attempt_limit,
    output var  logic                     link_failure_flag,
    output var  logic                     read_data_pending,
    output var  logic                     scan_active_flag,
    output var  logic                     mgmt_busy_flag,
    output var  mcms_pkg::mcms_coll_res_t coll_res
);
    import mcms_pkg::*;

    if (CW_W != mcms_pkg::CW_W || RETRY_W != mcms_pkg::RETRY_W) begin : g_bad_width
        $error("field widths are fixed by the register layout");
    end

    logic [CW_W-1:0]    cwin_q;
    logic [CW_W-1:0]    cwin_d;
    logic [RETRY_W-1:0] retry_attempt_limit_q;
    logic [RETRY_W-1:0] retry_attempt_limit_d;
    logic [IND_W-1:0]   mind_q;
    logic [IND_W-1:0]   mind_d;
    logic               dp_wr_q;
    logic               dp_reg_q;
    logic [1:0]         dp_op_q;
    logic [31:0]        dp_mask_q;
    logic               ahb_take;
    logic               addr_hit;
    logic [31:0]        clrt_new;
    logic [31:0]        mind_new;

    function automatic logic [31:0] lane_mask(input logic [2:0] size, input logic half_hi);
        if (size == HSIZE_WORD) begin
            lane_mask = LANE_ALL;
        end else if (size == HSIZE_HALF) begin
            lane_mask = half_hi ? LANE_HI : LANE_LO;
        end else begin
            lane_mask = '0;
        end
    endfunction

    function automatic logic [31:0] apply_op(input logic [1:0] op, input logic [31:0] old,
                                             input logic [31:0] wd, input logic [31:0] m);
        case (op)
            OP_CLR:  apply_op = old & ~(wd & m);
            OP_SET:  apply_op = old | (wd & m);
            OP_INV:  apply_op = old ^ (wd & m);
            default: apply_op = (old & ~m) | (wd & m);
        endcase
    endfunction

    function automatic logic [31:0] clrt_word(input logic [CW_W-1:0] cw, input logic [RETRY_W-1:0] rt);
        clrt_word = (32'(cw) << CWIN_LSB) | (32'(rt) << RETRY_ATTEMPT_LIMIT_LSB);
    endfunction

    assign ahb_take = hsel && htrans[1] && hready;
    assign addr_hit = haddr[31:MAP_TOP_LSB] == '0;

    // data phase bookkeeping; byte writes keep a zero mask, unmapped writes clear the write flag
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            dp_wr_q   <= 1'b0;
            dp_reg_q  <= 1'b0;
            dp_op_q   <= OP_BASE;
            dp_mask_q <= '0;
        end else if (hready) begin
            dp_wr_q   <= ahb_take && hwrite && addr_hit;
            dp_reg_q  <= haddr[REG_SEL_BIT];
            dp_op_q   <= haddr[3:2];
            dp_mask_q <= lane_mask(hsize, haddr[1]);
        end
    end

    always_comb begin
        clrt_new = apply_op(dp_op_q, clrt_word(cwin_q, retry_attempt_limit_q), hwdata, dp_mask_q) & CLRT_IMPL;
        mind_new = apply_op(dp_op_q, 32'(mind_q), hwdata, dp_mask_q) & MIND_IMPL;
        cwin_d   = cwin_q;
        retry_attempt_limit_d   = retry_attempt_limit_q;
        mind_d   = mind_q;
        if (dp_wr_q && !dp_reg_q) begin
            cwin_d = clrt_new[CWIN_LSB +: CW_W];
            retry_attempt_limit_d = clrt_new[RETRY_ATTEMPT_LIMIT_LSB +: RETRY_W];
        end
        if (dp_wr_q && dp_reg_q) begin
            mind_d = mind_new[IND_W-1:0];
        end
        // hardware events after the software write, so they win over it; among them a start beats a done
        if (mgmt_evt.done) begin
            mind_d[IND_BUSY] = 1'b0;
        end
        if (mgmt_evt.rdata_captured) begin
            mind_d[IND_PEND] = 1'b0;
        end
        if (mgmt_evt.start) begin
            mind_d[IND_BUSY] = 1'b1;
            if (mgmt_evt.is_read) begin
                mind_d[IND_PEND] = 1'b1;
            end
        end
        mind_d[IND_SCAN] = mgmt_evt.scan_active;
        if (mgmt_evt.status_valid) begin
            mind_d[IND_LINK] = mgmt_evt.link_fail;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            cwin_q <= CWIN_RST;
            retry_attempt_limit_q <= RETRY_ATTEMPT_LIMIT_RST;
        end else begin
            cwin_q <= cwin_d;
            retry_attempt_limit_q <= retry_attempt_limit_d;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            mind_q <= MIND_RST;
        end else begin
            mind_q <= mind_d;
        end
    end

    // read from next-state values so a read right behind a write sees it
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata <= '0;
        end else if (ahb_take && !hwrite) begin
            if (!addr_hit || lane_mask(hsize, haddr[1]) == '0) begin
                hrdata <= '0;
            end else if (haddr[REG_SEL_BIT]) begin
                hrdata <= 32'(mind_d) & MIND_IMPL;
            end else begin
                hrdata <= clrt_word(cwin_d, retry_attempt_limit_d) & CLRT_IMPL;
            end
        end
    end

    // zero-wait slave: never stalls, never errors
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
        end else begin
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
        end
    end

    assign collision_window_bytes = cwin_q;
    assign retry_attempt_limit    = retry_attempt_limit_q;
    assign link_failure_flag      = mind_q[IND_LINK];
    assign read_data_pending      = mind_q[IND_PEND];
    assign scan_active_flag       = mind_q[IND_SCAN];
    assign mgmt_busy_flag         = mind_q[IND_BUSY];

    mcms_coll_win #(
        .CW_W    (CW_W),
        .RETRY_W (RETRY_W)
    ) u_coll_win (
        .hclk         (hclk),
        .hresetn      (hresetn),
        .tx_evt       (tx_evt),
        .window_bytes (cwin_q),
        .retry_limit  (retry_attempt_limit_q),
        .coll_res     (coll_res)
    );

    // helper: marks the first clock after reset release
    logic after_rst_q;
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            after_rst_q <= 1'b0;
        end else begin
            after_rst_q <= 1'b1;
        end
    end

    // write data fields, named so the checks can take their past value
    logic [CW_W-1:0]    wd_cwin;
    logic [RETRY_W-1:0] wd_retry_attempt_limit;
    assign wd_cwin = hwdata[CWIN_LSB +: CW_W];
    assign wd_retry_attempt_limit = hwdata[RETRY_ATTEMPT_LIMIT_LSB +: RETRY_W];

    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);

    sequence s_read_start;
        mgmt_evt.start && mgmt_evt.is_read;
    endsequence

    sequence s_byte_write;
        ahb_take && hwrite && addr_hit && hsize != HSIZE_HALF && hsize != HSIZE_WORD;
    endsequence

    // data phase of a base write whose lanes reach the low half
    sequence s_low_write;
        dp_wr_q && !dp_reg_q && dp_mask_q[0] && dp_op_q == OP_BASE;
    endsequence

    sequence s_high_write;
        dp_wr_q && !dp_reg_q && dp_mask_q == LANE_HI;
    endsequence

    sequence s_clrt_read;
        ahb_take && !hwrite && addr_hit && hsize == HSIZE_WORD && !haddr[REG_SEL_BIT];
    endsequence

    sequence s_mind_read;
        ahb_take && !hwrite && addr_hit && hsize == HSIZE_WORD && haddr[REG_SEL_BIT];
    endsequence

    reset_values_a: assert property (!after_rst_q |-> cwin_q == 6'h37 && retry_attempt_limit_q == 4'hf)
        else $error("collision register reset value wrong");
    retry_reset_a: assert property (!after_rst_q |-> retry_attempt_limit == 4'hf)
        else $error("retry limit not 15 after reset");
    byte_ignored_a: assert property (s_byte_write ##1 !mgmt_evt.start |=> $stable(cwin_q) && $stable(retry_attempt_limit_q))
        else $error("byte write changed collision register");
    link_mirror_a: assert property (mgmt_evt.status_valid |=> link_failure_flag == $past(mgmt_evt.link_fail))
        else $error("link failure bit does not follow status");
    pend_on_read_a: assert property (s_read_start |=> read_data_pending && mgmt_busy_flag)
        else $error("read start did not raise pending and busy");
    scan_follow_a: assert property (mgmt_evt.scan_active |=> scan_active_flag)
        else $error("scan bit not set while scanning");
    busy_on_write_a: assert property (mgmt_evt.start && !mgmt_evt.is_read |=> mgmt_busy_flag)
        else $error("write cycle did not raise busy");
    zero_bits_a: assert property (ahb_take && !hwrite |=> (hrdata & ~(CLRT_IMPL | MIND_IMPL)) == '0)
        else $error("unimplemented bits read non-zero");
    clear_done_a: assert property (mgmt_evt.done && mgmt_evt.rdata_captured && !mgmt_evt.start
        |=> !mgmt_busy_flag && !read_data_pending)
        else $error("busy or pending left set after completion");
    window_out_a: assert property (s_low_write |=> collision_window_bytes == $past(wd_cwin))
        else $error("window field not loaded from write data");

    // field mapping, lanes and aliases
    retry_out_a: assert property (s_low_write |=> retry_attempt_limit == $past(wd_retry_attempt_limit))
        else $error("retry field not loaded from write data");
    high_half_a: assert property (s_high_write |=> $stable(cwin_q) && $stable(retry_attempt_limit_q))
        else $error("upper halfword write changed collision register");
    clr_alias_a: assert property (dp_wr_q && !dp_reg_q && dp_mask_q[0] && dp_op_q == OP_CLR
        |=> (collision_window_bytes & $past(wd_cwin)) == '0)
        else $error("clear alias left window bits set");
    set_alias_a: assert property (dp_wr_q && !dp_reg_q && dp_mask_q[0] && dp_op_q == OP_SET
        |=> (collision_window_bytes & $past(wd_cwin)) == $past(wd_cwin))
        else $error("set alias did not set window bits");
    inv_alias_a: assert property (dp_wr_q && !dp_reg_q && dp_mask_q[0] && dp_op_q == OP_INV
        |=> retry_attempt_limit == ($past(retry_attempt_limit_q) ^ $past(wd_retry_attempt_limit)))
        else $error("invert alias did not toggle retry bits");
    unmapped_wr_a: assert property (ahb_take && hwrite && !addr_hit ##1 1'b1
        |=> $stable(cwin_q) && $stable(retry_attempt_limit_q))
        else $error("unmapped write changed collision register");

    // read data against the visible fields, and the transfer response
    clrt_readback_a: assert property (s_clrt_read
        |=> hrdata == {18'h0, collision_window_bytes, 4'h0, retry_attempt_limit})
        else $error("collision register read mismatch");
    mind_readback_a: assert property (s_mind_read
        |=> hrdata == {28'h0, link_failure_flag, read_data_pending, scan_active_flag, mgmt_busy_flag})
        else $error("indicator register read mismatch");
    byte_read_a: assert property (ahb_take && !hwrite && hsize != HSIZE_HALF && hsize != HSIZE_WORD
        |=> hrdata == '0)
        else $error("byte read returned data");
    okay_resp_a: assert property (ahb_take |=> hreadyout && !hresp)
        else $error("transfer not answered ready and okay");

    // completion clears, and a same-cycle start wins
    busy_clear_a: assert property (mgmt_evt.done && !mgmt_evt.start |=> !mgmt_busy_flag)
        else $error("busy left set after cycle done");
    pend_clear_a: assert property (mgmt_evt.rdata_captured && !(mgmt_evt.start && mgmt_evt.is_read)
        |=> !read_data_pending)
        else $error("pending left set after data captured");
    busy_wins_a: assert property (mgmt_evt.start && mgmt_evt.done |=> mgmt_busy_flag)
        else $error("clear beat a same-cycle start of busy");
    pend_wins_a: assert property (s_read_start ##0 mgmt_evt.rdata_captured |=> read_data_pending)
        else $error("clear beat a same-cycle read start");
    pend_needs_read_a: assert property (mgmt_evt.start && !mgmt_evt.is_read && !read_data_pending
        && !(dp_wr_q && dp_reg_q) |=> !read_data_pending)
        else $error("write cycle raised read pending");
    scan_drop_a: assert property (!mgmt_evt.scan_active |=> !scan_active_flag)
        else $error("scan bit set while not scanning");
    link_hold_a: assert property (!mgmt_evt.status_valid && !(dp_wr_q && dp_reg_q)
        |=> $stable(link_failure_flag))
        else $error("link failure bit moved without new status");
endmodule
`default_nettype wire

/* verification/mcms_phy_model.sv */
// behavioural phy and transmit path: management and transmit event source
`timescale 1ns/100ps
`default_nettype none
module mcms_phy_model (
    input  wire logic                     hclk,
    output var  mcms_pkg::mcms_mgmt_evt_t mgmt_evt,
    output var  mcms_pkg::mcms_tx_evt_t   tx_evt
);
    import mcms_pkg::*;
    initial begin
        mgmt_evt = '0;
        tx_evt   = '0;
    end
    // levels riding a strobe are inverted after it, so stale data never looks valid
    task automatic mgmt(input logic st, input logic rd, input logic dn, input logic cap, input logic sv,
                        input logic lf);
        @(posedge hclk);
        mgmt_evt <= {st, rd, dn, cap, mgmt_evt.scan_active, sv, lf};
        @(posedge hclk);
        mgmt_evt <= {1'b0, ~rd, 1'b0, 1'b0, mgmt_evt.scan_active, 1'b0, ~lf};
    endtask
    task automatic scan(input logic on);
        @(posedge hclk);
        mgmt_evt.scan_active <= on;
    endtask
    // optional start, byte ticks, then one cycle of collision and done
    task automatic tx(input logic st, input int ticks, input logic coll, input logic dn);
        @(posedge hclk);
        tx_evt <= {st, 3'b000};
        repeat (ticks) begin
            @(posedge hclk);
            tx_evt <= 4'b0100;
        end
        @(posedge hclk);
        tx_evt <= {2'b00, coll, dn};
        @(posedge hclk);
        tx_evt <= '0;
    endtask
endmodule
`default_nettype wire

/* verification/mcms_tb_top.sv */
// self-checking bench for collision window, retry limit and management indicators
`timescale 1ns/100ps
`default_nettype none
module mcms_tb_top;
    import mcms_pkg::*;
    logic           hclk;
    logic           hresetn;
    logic           hsel;
    logic [31:0]    haddr;
    logic [1:0]     htrans;
    logic           hwrite;
    logic [2:0]     hsize;
    logic [31:0]    hwdata;
    logic [31:0]    hrdata;
    logic           hreadyout;
    logic           hresp;
    logic [5:0]     cw_bytes;
    logic [3:0]     retry_lim;
    logic           link_f;
    logic           pend_f;
    logic           scan_f;
    logic           busy_f;
    mcms_mgmt_evt_t mgmt_evt;
    mcms_tx_evt_t   tx_evt;
    mcms_coll_res_t coll_res;
    int             miscompares = 0;
    int             check_count = 0;
    int             cycles = 0;

    mcms_top i_dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
        .hreadyout(hreadyout), .hresp(hresp), .mgmt_evt(mgmt_evt), .tx_evt(tx_evt),
        .collision_window_bytes(cw_bytes), .retry_attempt_limit(retry_lim), .link_failure_flag(link_f),
        .read_data_pending(pend_f), .scan_active_flag(scan_f), .mgmt_busy_flag(busy_f), .coll_res(coll_res));
    mcms_phy_model phy (.hclk(hclk), .mgmt_evt(mgmt_evt), .tx_evt(tx_evt));

    initial begin
        hclk = 1'b0;
        forever #12.5 hclk = ~hclk;
    end
    // whole run needs well under 2000 cycles
    always @(posedge hclk) begin
        cycles++;
        if (cycles == 5000) begin
            miscompares++;
            summarize();
        end
    end

    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            miscompares++;
            $display("[ERR] %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic summarize();
        $display("checks %0d miscompares %0d", check_count, miscompares);
        if (miscompares == 0 && check_count > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    task automatic ahb(input logic wr, input logic [31:0] a, input logic [2:0] sz, input logic [31:0] wd,
                       output logic [31:0] rd);
        @(posedge hclk);
        hsel   <= 1'b1;
        haddr  <= a;
        htrans <= 2'h2;
        hwrite <= wr;
        hsize  <= sz;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        hsel   <= 1'b0;
        htrans <= 2'h0;
        hwdata <= wd;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        rd = hrdata;
    endtask
    task automatic wr(input logic [31:0] a, input logic [31:0] d, input logic [2:0] sz);
        logic [31:0] unused;
        ahb(1'b1, a, sz, d, unused);
    endtask
    task automatic rdc(input string name, input logic [31:0] a, input logic [31:0] exp);
        logic [31:0] v;
        ahb(1'b0, a, HSIZE_WORD, 32'h0, v);
        check(name, v, exp);
    endtask
    task automatic ind_chk(input logic [3:0] exp);
        repeat (2) @(posedge hclk);
        #1;
        check("indicators", {28'h0, link_f, pend_f, scan_f, busy_f}, {28'h0, exp});
    endtask
    task automatic coll_chk(input logic [2:0] exp);
        #1;
        check("coll_res", {29'h0, coll_res}, {29'h0, exp});
    endtask

    task automatic t_reset();
        rdc("clrt", OFF_CLRT, 32'h0000_370f);
        check("window", {26'h0, cw_bytes}, 32'h0000_0037);
        check("retry", {28'h0, retry_lim}, 32'h0000_000f);
        rdc("mind", OFF_MIND, 32'h0000_0000);
        check("hreadyout", {31'h0, hreadyout}, 32'h0000_0001);
        check("hresp", {31'h0, hresp}, 32'h0000_0000);
    endtask
    // word writes and the clear, set and invert aliases; aliases read the base
    task automatic t_regs();
        wr(OFF_CLRT, 32'hffff_ffff, HSIZE_WORD);
        rdc("clrt", OFF_CLRT, 32'h0000_3f0f);
        check("window", {26'h0, cw_bytes}, 32'h0000_003f);
        wr(OFF_CLRT + 32'h4, 32'h0000_0f00, HSIZE_WORD);
        rdc("clrt", OFF_CLRT + 32'h8, 32'h0000_300f);
        wr(OFF_CLRT + 32'h8, 32'h0000_0c30, HSIZE_WORD);
        rdc("clrt", OFF_CLRT, 32'h0000_3c0f);
        wr(OFF_CLRT + 32'hc, 32'h0000_0005, HSIZE_WORD);
        rdc("clrt", OFF_CLRT + 32'hc, 32'h0000_3c0a);
    endtask
    // halfword lanes, ignored byte accesses, unmapped place
    task automatic t_sizes();
        logic [31:0] v;
        wr(OFF_CLRT + 32'h2, 32'hffff_ffff, HSIZE_HALF);
        rdc("clrt", OFF_CLRT, 32'h0000_3c0a);
        wr(OFF_CLRT, 32'hffff_1205, HSIZE_HALF);
        rdc("clrt", OFF_CLRT, 32'h0000_1205);
        wr(OFF_CLRT, 32'h0000_0000, 3'h0);
        ahb(1'b0, OFF_CLRT, 3'h0, 32'h0, v);
        check("byte read", v, 32'h0000_0000);
        wr(32'h0000_0020, 32'hffff_ffff, HSIZE_WORD);
        rdc("unmapped", 32'h0000_0020, 32'h0000_0000);
        rdc("clrt", OFF_CLRT, 32'h0000_1205);
        ahb(1'b0, OFF_CLRT + 32'h2, HSIZE_HALF, 32'h0, v);
        check("half read", v, 32'h0000_1205);
    endtask
    task automatic t_mgmt();
        phy.mgmt(1, 1, 0, 0, 0, 0);
        ind_chk(4'h5);
        rdc("mind", OFF_MIND, 32'h0000_0005);
        phy.mgmt(0, 0, 1, 1, 0, 0);
        ind_chk(4'h0);
        phy.mgmt(1, 0, 0, 0, 0, 0);
        ind_chk(4'h1);
        phy.mgmt(1, 0, 1, 0, 0, 0);
        ind_chk(4'h1);
        phy.mgmt(1, 1, 0, 1, 0, 0);
        ind_chk(4'h5);
        phy.mgmt(0, 0, 1, 0, 0, 0);
        ind_chk(4'h4);
        phy.mgmt(0, 0, 0, 1, 0, 0);
        ind_chk(4'h0);
        wr(OFF_MIND + 32'h8, 32'h0000_0004, HSIZE_WORD);
        ind_chk(4'h4);
        wr(OFF_MIND + 32'h4, 32'h0000_000c, HSIZE_WORD);
        ind_chk(4'h0);
        phy.mgmt(0, 0, 0, 0, 1, 1);
        ind_chk(4'h8);
        phy.scan(1'b1);
        ind_chk(4'ha);
        rdc("mind", OFF_MIND, 32'h0000_000a);
        phy.scan(1'b0);
        phy.mgmt(0, 0, 0, 0, 1, 0);
        ind_chk(4'h0);
    endtask
    // window 55 bytes, limit 2: two retries then abort; last in-window byte and first late byte
    task automatic t_coll();
        wr(OFF_CLRT, 32'h0000_3702, HSIZE_WORD);
        for (int i = 0; i < 3; i++) begin
            phy.tx(1'b1, 5, 1'b1, 1'b0);
            coll_chk(i < 2 ? 3'b100 : 3'b010);
        end
        phy.tx(1'b1, 54, 1'b1, 1'b0);
        coll_chk(3'b100);
        phy.tx(1'b1, 55, 1'b1, 1'b0);
        coll_chk(3'b001);
        phy.tx(1'b1, 2, 1'b1, 1'b0);
        coll_chk(3'b100);
        phy.tx(1'b0, 0, 1'b0, 1'b1);
        phy.tx(1'b1, 0, 1'b1, 1'b0);
        coll_chk(3'b100);
    endtask

    initial begin
        hresetn = 1'b0;
        hsel    = 1'b0;
        haddr   = 32'h0;
        htrans  = 2'h0;
        hwrite  = 1'b0;
        hsize   = 3'h0;
        hwdata  = 32'h0;
        repeat (6) @(posedge hclk);
        hresetn <= 1'b1;
        t_reset();
        t_regs();
        t_sizes();
        t_mgmt();
        t_coll();
        summarize();
    end
endmodule
`default_nettype wire
